/* File: hpfs_pin_select.sv */
`default_nettype none
module hpfs_pin_select #(
  parameter int unsigned GPIO_W = hpfs_pkg::GPIO_COUNT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host-side pins
  input wire logic if_select,
  input wire logic chip_sel_or_addr_sel0,
  input wire logic spi_in_or_addr_sel1,
  output logic spi_out,
  output logic spi_out_oe_n,
  output logic irq_out,
  output logic irq_oe_n,
  // general-purpose pins
  input wire logic [GPIO_W-1:0] gpio_in,
  output logic [GPIO_W-1:0] gpio_out,
  output logic [GPIO_W-1:0] gpio_oe_n,
  // decoded host pin roles to the host interface logic
  output hpfs_pkg::hpfs_mode_type host_mode,
  output hpfs_pkg::hpfs_host_pins_type host_pins,
  // serial output data from the spi slave
  input wire logic spi_sdo_data,
  input wire logic spi_sdo_active,
  // interrupt enables and sources per channel
  input wire logic [hpfs_pkg::IE_WIDTH-1:0] interrupt_enable_reg_a,
  input wire logic [hpfs_pkg::IE_WIDTH-1:0] interrupt_enable_reg_b,
  input wire hpfs_pkg::hpfs_irq_src_type irq_src_a,
  input wire hpfs_pkg::hpfs_irq_src_type irq_src_b,
  // input-change interrupt enable and clear per pin
  input wire logic [GPIO_W-1:0] gpio_change_en,
  input wire logic [GPIO_W-1:0] gpio_change_clr,
  output logic [GPIO_W-1:0] gpio_change_flag,
  // general-purpose io control and readback
  input wire logic modem_pins_a,
  input wire logic modem_pins_b,
  input wire logic [GPIO_W-1:0] gpio_dir_out,
  input wire logic [GPIO_W-1:0] gpio_data_out,
  output logic [GPIO_W-1:0] gpio_state,
  // modem lines to and from the uart channels
  input wire logic dtr_n_a,
  input wire logic dtr_n_b,
  output hpfs_pkg::hpfs_modem_in_type modem_in_a,
  output hpfs_pkg::hpfs_modem_in_type modem_in_b
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [2:0] host_sync;
  logic [GPIO_W-1:0] gpio_sync;
  logic [GPIO_W-1:0] gpio_prev;

  hpfs_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h6)
  ) u_host_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({if_select, chip_sel_or_addr_sel0, spi_in_or_addr_sel1}),
    .sync_out(host_sync)
  );

  hpfs_sync #(
    .WIDTH(GPIO_W),
    .RESET_VALUE('0)
  ) u_gpio_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(gpio_in),
    .sync_out(gpio_sync)
  );

  // ==========================================================
  // host interface selection
  // ==========================================================
  wire sel_i2c = host_sync[2];
  wire first_in = host_sync[1];
  wire second_in = host_sync[0];
  // same synced inputs as host_pins, so enable and decoded roles agree
  wire cs_active = ~sel_i2c & ~first_in;
  wire next_out_drive = cs_active & spi_sdo_active;

  hpfs_pkg::hpfs_mode_type next_mode;
  assign next_mode = sel_i2c ? hpfs_pkg::HPFS_MODE_I2C
                             : hpfs_pkg::HPFS_MODE_SPI;

  hpfs_pkg::hpfs_host_pins_type next_host_pins;
  // in i2c mode the chip select reads inactive; in spi mode address is zero
  assign next_host_pins.spi_cs_n = sel_i2c | first_in;
  assign next_host_pins.spi_sdi = sel_i2c ? 1'b0 : second_in;
  assign next_host_pins.addr_sel = sel_i2c ? {second_in, first_in}
                                           : 2'b00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_mode <= hpfs_pkg::HPFS_MODE_I2C;
      host_pins <= '{spi_cs_n: 1'b1, spi_sdi: 1'b0, addr_sel: 2'b00};
    end else begin
      host_mode <= next_mode;
      host_pins <= next_host_pins;
    end
  end

  // ==========================================================
  // spi serial output
  // ==========================================================
  // the spi slave's data is ignored in i2c mode; output stays released
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spi_out <= 1'b0;
      spi_out_oe_n <= 1'b1;
    end else begin
      spi_out <= next_out_drive & spi_sdo_data;
      spi_out_oe_n <= ~next_out_drive;
    end
  end

  // ==========================================================
  // general-purpose pin roles
  // ==========================================================
  function automatic logic [3:0] group_oe_n(
    input logic modem_sel,
    input logic [3:0] dir_out
  );
    logic [3:0] oe_n;
    oe_n = ~dir_out;
    if (modem_sel) begin
      oe_n = 4'hf;
      oe_n[hpfs_pkg::MODEM_DTR_POS] = 1'b0;
    end
    return oe_n;
  endfunction : group_oe_n

  function automatic logic [3:0] group_out(
    input logic modem_sel,
    input logic [3:0] data_out,
    input logic dtr_n
  );
    logic [3:0] val;
    val = modem_sel ? 4'h0 : data_out;
    if (modem_sel) begin
      val[hpfs_pkg::MODEM_DTR_POS] = dtr_n;
    end
    return val;
  endfunction : group_out

  function automatic hpfs_pkg::hpfs_modem_in_type group_modem_in(
    input logic modem_sel,
    input logic [3:0] pins
  );
    hpfs_pkg::hpfs_modem_in_type m;
    m.dsr_n = hpfs_pkg::MODEM_IN_IDLE_N;
    m.cd_n = hpfs_pkg::MODEM_IN_IDLE_N;
    m.ri_n = hpfs_pkg::MODEM_IN_IDLE_N;
    if (modem_sel) begin
      m.dsr_n = pins[hpfs_pkg::MODEM_DSR_POS];
      m.cd_n = pins[hpfs_pkg::MODEM_CD_POS];
      m.ri_n = pins[hpfs_pkg::MODEM_RI_POS];
    end
    return m;
  endfunction : group_modem_in

  localparam int unsigned BB = hpfs_pkg::CHAN_B_BASE;
  localparam int unsigned AB = hpfs_pkg::CHAN_A_BASE;
  localparam int unsigned GP = hpfs_pkg::GROUP_PINS;

  wire [GPIO_W-1:0] next_gpio_oe_n = {
    group_oe_n(modem_pins_a, gpio_dir_out[AB +: GP]),
    group_oe_n(modem_pins_b, gpio_dir_out[BB +: GP])
  };
  wire [GPIO_W-1:0] next_gpio_out = {
    group_out(modem_pins_a, gpio_data_out[AB +: GP], dtr_n_a),
    group_out(modem_pins_b, gpio_data_out[BB +: GP], dtr_n_b)
  };
  wire [GPIO_W-1:0] io_input_mode = {
    {GP{~modem_pins_a}} & ~gpio_dir_out[AB +: GP],
    {GP{~modem_pins_b}} & ~gpio_dir_out[BB +: GP]
  };

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpio_oe_n <= '1;
      gpio_out <= '0;
      gpio_state <= hpfs_pkg::GPIO_RESET;
      gpio_prev <= hpfs_pkg::GPIO_RESET;
      modem_in_a <= '1;
      modem_in_b <= '1;
    end else begin
      gpio_oe_n <= next_gpio_oe_n;
      gpio_out <= next_gpio_out;
      gpio_state <= gpio_sync;
      gpio_prev <= gpio_sync;
      modem_in_a <= group_modem_in(modem_pins_a, gpio_sync[AB +: GP]);
      modem_in_b <= group_modem_in(modem_pins_b, gpio_sync[BB +: GP]);
    end
  end

  // ==========================================================
  // input change flags
  // ==========================================================
  // a change arriving with its clear keeps the flag set
  wire [GPIO_W-1:0] pin_changed = (gpio_sync ^ gpio_prev) & io_input_mode;
  wire [GPIO_W-1:0] next_change_flag =
    pin_changed | (gpio_change_flag & ~gpio_change_clr);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpio_change_flag <= '0;
    end else begin
      gpio_change_flag <= next_change_flag;
    end
  end

  // ==========================================================
  // interrupt output
  // ==========================================================
  function automatic logic chan_pending(
    input logic [hpfs_pkg::IE_WIDTH-1:0] en,
    input hpfs_pkg::hpfs_irq_src_type src
  );
    logic p;
    p = (en[hpfs_pkg::IE_RX_DATA_POS] & src.rx_data)
      | (en[hpfs_pkg::IE_TX_SPACE_POS] & src.tx_space)
      | (en[hpfs_pkg::IE_RX_ERROR_POS] & src.rx_error)
      | (en[hpfs_pkg::IE_MODEM_POS] & src.modem_status);
    return p;
  endfunction : chan_pending

  wire pend_a = chan_pending(interrupt_enable_reg_a, irq_src_a);
  wire pend_b = chan_pending(interrupt_enable_reg_b, irq_src_b);
  wire pend_io = |(gpio_change_flag & gpio_change_en);
  wire next_irq = pend_a | pend_b | pend_io;

  logic irq_drive;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_drive <= hpfs_pkg::IRQ_DRIVE_RESET;
    end else begin
      irq_drive <= next_irq;
    end
  end

  // open drain: data is always low, only the enable moves
  assign irq_out = 1'b0;
  assign irq_oe_n = ~irq_drive;

endmodule : hpfs_pin_select
`default_nettype wire

/* File: hpfs_pkg.sv */
`default_nettype none
package hpfs_pkg;

  // host interface chosen by the interface-select pin
  typedef enum logic [1:0] {
    HPFS_MODE_SPI = 2'b01,
    HPFS_MODE_I2C = 2'b10
  } hpfs_mode_type;

  // number of shared general-purpose pins and pins per modem group
  localparam int unsigned GPIO_COUNT = 8;
  localparam int unsigned GROUP_PINS = 4;

  // pin index within a modem group
  localparam int unsigned MODEM_DSR_POS = 0;
  localparam int unsigned MODEM_DTR_POS = 1;
  localparam int unsigned MODEM_CD_POS = 2;
  localparam int unsigned MODEM_RI_POS = 3;

  // first pin of each channel's modem group
  localparam int unsigned CHAN_B_BASE = 0;
  localparam int unsigned CHAN_A_BASE = 4;

  // reset values and the idle level of the modem inputs
  localparam logic IRQ_DRIVE_RESET = 1'b0;
  localparam logic MODEM_IN_IDLE_N = 1'b1;
  localparam logic [7:0] GPIO_RESET = 8'h00;

  // interrupt enable bit positions, one copy per channel
  localparam int unsigned IE_RX_DATA_POS = 0;
  localparam int unsigned IE_TX_SPACE_POS = 1;
  localparam int unsigned IE_RX_ERROR_POS = 2;
  localparam int unsigned IE_MODEM_POS = 3;
  localparam int unsigned IE_WIDTH = 4;

  // per-channel interrupt source levels from the uart core
  typedef struct packed {
    logic modem_status;
    logic rx_error;
    logic tx_space;
    logic rx_data;
  } hpfs_irq_src_type;

  // modem input lines (dsr, cd, ri) of one channel, active low as on the wire
  typedef struct packed {
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } hpfs_modem_in_type;

  // decoded host-side pin roles
  typedef struct packed {
    logic spi_cs_n;
    logic spi_sdi;
    logic [1:0] addr_sel;
  } hpfs_host_pins_type;

endpackage : hpfs_pkg
`default_nettype wire

/* File: hpfs_sync.sv */
`default_nettype none
// two-stage synchroniser for pin inputs
module hpfs_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : hpfs_sync
`default_nettype wire

/* File: hpfs_host_model.sv */
`default_nettype none
// host side: drives the select and shared pins, watches the serial output
module hpfs_host_model (
  // clock
  input wire logic sys_clk,
  // pin levels wanted by the bench
  input wire logic want_i2c,
  input wire logic want_cs_n,
  input wire logic want_si,
  // serial output of the device
  input wire logic spi_out,
  input wire logic spi_out_oe_n,
  // pins toward the device and the resolved serial line
  output logic if_select,
  output logic cs_pin,
  output logic si_pin,
  output logic so_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic so_last;
  initial begin
    {if_select, cs_pin, si_pin, so_last} = 4'hc;
  end
  always @(posedge sys_clk) begin
    if_select <= want_i2c;
    cs_pin <= want_cs_n;
    si_pin <= want_si;
    if (!spi_out_oe_n) so_last <= spi_out;
  end
  // released line floats: show the inverse of the last driven level
  assign so_line = spi_out_oe_n ? !so_last : spi_out;
endmodule : hpfs_host_model
`default_nettype wire

/* File: hpfs_chk.sv */
`default_nettype none
module hpfs_chk #(
  parameter int unsigned GPIO_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host pins
  input wire logic if_select,
  input wire logic chip_sel_or_addr_sel0,
  input wire logic spi_in_or_addr_sel1,
  input wire logic spi_out,
  input wire logic spi_out_oe_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire hpfs_pkg::hpfs_mode_type host_mode,
  input wire hpfs_pkg::hpfs_host_pins_type host_pins,
  input wire logic spi_sdo_data,
  input wire logic spi_sdo_active,
  // interrupts
  input wire logic [3:0] interrupt_enable_reg_a,
  input wire logic [3:0] interrupt_enable_reg_b,
  input wire hpfs_pkg::hpfs_irq_src_type irq_src_a,
  input wire hpfs_pkg::hpfs_irq_src_type irq_src_b,
  input wire logic [GPIO_W-1:0] gpio_change_en,
  input wire logic [GPIO_W-1:0] gpio_change_flag,
  // general-purpose pins
  input wire logic [GPIO_W-1:0] gpio_in,
  input wire logic [GPIO_W-1:0] gpio_out,
  input wire logic [GPIO_W-1:0] gpio_oe_n,
  input wire logic modem_pins_a,
  input wire logic modem_pins_b,
  input wire logic dtr_n_a,
  input wire logic dtr_n_b
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // helpers
  logic [2:0] warm;
  logic pend;
  logic spi;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) warm <= 3'h0;
    else if (warm != 3'h4) warm <= warm + 3'h1;
  assign pend = |(interrupt_enable_reg_a & irq_src_a) |
    |(interrupt_enable_reg_b & irq_src_b) |
    |(gpio_change_en & gpio_change_flag);
  assign spi = host_mode == hpfs_pkg::HPFS_MODE_SPI;
  sequence pin0_moved;
    warm < 3'h4 || $past(gpio_in[0], 3) != $past(gpio_in[0], 4);
  endsequence
  // ==========================================
  // assertions
  irq_od_a: assert property (irq_out == 1'b0)
    else $error("interrupt data not low");
  irq_set_a: assert property (pend |=> !irq_oe_n)
    else $error("pending interrupt not driven");
  irq_clr_a: assert property (!pend |=> irq_oe_n)
    else $error("interrupt driven without cause");
  mode_sel_a: assert property (warm > 3'h2 |-> host_mode ==
    ($past(if_select, 3) ? hpfs_pkg::HPFS_MODE_I2C : hpfs_pkg::HPFS_MODE_SPI))
    else $error("mode does not follow select pin");
  spi_pins_a: assert property (warm > 3'h2 && spi |->
    host_pins ==
    {$past(chip_sel_or_addr_sel0, 3), $past(spi_in_or_addr_sel1, 3), 2'h0})
    else $error("spi pin roles wrong");
  i2c_addr_a: assert property (warm > 3'h2 && !spi |->
    host_pins == {2'h2, $past(spi_in_or_addr_sel1, 3),
    $past(chip_sel_or_addr_sel0, 3)})
    else $error("address select wrong");
  sdo_en_a: assert property (warm > 3'h2 |-> spi_out_oe_n ==
    !(spi && !host_pins.spi_cs_n && $past(spi_sdo_active)))
    else $error("serial output enable wrong");
  sdo_data_a: assert property (
    spi_out == (!spi_out_oe_n && $past(spi_sdo_data)))
    else $error("serial output data wrong");
  modem_b_a: assert property (modem_pins_b |=>
    gpio_oe_n[3:0] == 4'hd && gpio_out[1] == $past(dtr_n_b))
    else $error("channel b modem pins wrong");
  modem_a_a: assert property (modem_pins_a |=>
    gpio_oe_n[7:4] == 4'hd && gpio_out[5] == $past(dtr_n_a))
    else $error("channel a modem pins wrong");
  chg_flag_a: assert property (
    $rose(gpio_change_flag[0]) |-> pin0_moved)
    else $error("change flag without pin change");
endmodule : hpfs_chk
bind hpfs_pin_select hpfs_chk #(.GPIO_W(GPIO_W)) hpfs_chk_i (.sys_clk, .rst,
  .if_select, .chip_sel_or_addr_sel0, .spi_in_or_addr_sel1, .spi_out,
  .spi_out_oe_n, .irq_out, .irq_oe_n, .host_mode, .host_pins, .spi_sdo_data,
  .spi_sdo_active, .interrupt_enable_reg_a, .interrupt_enable_reg_b,
  .irq_src_a, .irq_src_b, .gpio_change_en, .gpio_change_flag, .gpio_in,
  .gpio_out, .gpio_oe_n, .modem_pins_a, .modem_pins_b, .dtr_n_a, .dtr_n_b);
`default_nettype wire

/* File: test_host_pin_function_select.sv */
`default_nettype none
module test_host_pin_function_select;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // signals
  logic sys_clk, rst, want_i2c, want_cs_n, want_si, if_select, cs_pin, si_pin;
  logic so_line, irq_line, spi_out, spi_out_oe_n, irq_out, irq_oe_n;
  logic spi_sdo_data, spi_sdo_active, modem_pins_a, modem_pins_b;
  logic dtr_n_a, dtr_n_b;
  logic [3:0] ie_a, ie_b;
  hpfs_pkg::hpfs_irq_src_type src_a, src_b;
  logic [7:0] gpio_in, gpio_out, gpio_oe_n, chg_en, chg_clr, chg_flag;
  logic [7:0] dir_out, data_out, gpio_state;
  hpfs_pkg::hpfs_mode_type host_mode;
  hpfs_pkg::hpfs_host_pins_type host_pins;
  hpfs_pkg::hpfs_modem_in_type min_a, min_b;
  int num_errors, total_checks, cycles, b, d;
  // pull-up on the open-drain interrupt line
  assign irq_line = irq_oe_n ? 1'b1 : irq_out;
  hpfs_host_model hpfs_host_model_i (.sys_clk, .want_i2c, .want_cs_n,
    .want_si, .spi_out, .spi_out_oe_n, .if_select, .cs_pin, .si_pin,
    .so_line);
  hpfs_pin_select hpfs_pin_select_i (.sys_clk, .rst, .if_select,
    .chip_sel_or_addr_sel0(cs_pin), .spi_in_or_addr_sel1(si_pin), .spi_out,
    .spi_out_oe_n, .irq_out, .irq_oe_n, .gpio_in, .gpio_out, .gpio_oe_n,
    .host_mode, .host_pins, .spi_sdo_data, .spi_sdo_active,
    .interrupt_enable_reg_a(ie_a), .interrupt_enable_reg_b(ie_b),
    .irq_src_a(src_a), .irq_src_b(src_b), .gpio_change_en(chg_en),
    .gpio_change_clr(chg_clr), .gpio_change_flag(chg_flag), .modem_pins_a,
    .modem_pins_b, .gpio_dir_out(dir_out), .gpio_data_out(data_out),
    .gpio_state, .dtr_n_a, .dtr_n_b, .modem_in_a(min_a), .modem_in_b(min_b));
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================
  // tests
  initial begin
    logic [1:0] e;
    {rst, want_i2c, want_cs_n, want_si, spi_sdo_data} = 5'h1c;
    {spi_sdo_active, modem_pins_a, modem_pins_b, dtr_n_a, dtr_n_b} = '0;
    {ie_a, ie_b, src_a, src_b, gpio_in, chg_en, chg_clr} = '0;
    {dir_out, data_out} = '0;
    void'($urandom(55296));
    tick(8);
    #1;
    check("irq", irq_line, 8'h01);
    check("sdo_oe", spi_out_oe_n, 8'h01);
    check("mode", host_mode, 8'h02);
    tick(1);
    rst <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      b = $urandom;
      want_i2c <= i[0];
      want_cs_n <= b[0];
      want_si <= b[1];
      tick(6);
      #1;
      check("mode", host_mode, i[0] ? 8'h02 : 8'h01);
      check("pins", host_pins, i[0] ? {6'h02, b[1], b[0]}
        : {4'h0, b[0], b[1], 2'h0});
      tick(1);
    end
    $display("test pins done");
    for (int j = 0; j < 6; j++) begin
      d = $urandom;
      want_i2c <= (j > 3);
      want_cs_n <= (j == 3);
      spi_sdo_active <= (j != 2);
      spi_sdo_data <= d[0];
      tick(6);
      #1;
      e = (j < 2) ? {1'b0, d[0]} : 2'h2;
      check("sdo_oe", spi_out_oe_n, e[1]);
      check("sdo", spi_out, e[0]);
      if (!e[1]) check("so_line", so_line, e[0]);
      tick(1);
    end
    $display("test serial out done");
    for (int k = 0; k < 16; k++) begin
      b = 1 << (k % 4);
      d = (k & 4) ? b : 15 - b;
      ie_a <= (k < 8) ? d[3:0] : 4'h0;
      src_a <= (k < 8) ? b[3:0] : 4'h0;
      ie_b <= (k < 8) ? 4'h0 : d[3:0];
      src_b <= (k < 8) ? 4'h0 : b[3:0];
      tick(2);
      #1;
      check("irq", irq_line, {7'h0, (d & b) == 0});
      tick(1);
    end
    $display("test interrupt done");
    {ie_a, ie_b, src_a, src_b} <= '0;
    chg_en <= 8'h01;
    dir_out <= 8'h04;
    data_out <= 8'h04;
    tick(4);
    gpio_in <= 8'h05;
    tick(6);
    #1;
    check("flag", chg_flag, 8'h01);
    check("irq", irq_line, 8'h00);
    check("gpio_oe", gpio_oe_n, 8'hfb);
    check("gpio_out", gpio_out, 8'h04);
    tick(1);
    chg_clr <= 8'h01;
    tick(1);
    chg_clr <= 8'h00;
    tick(3);
    #1;
    check("flag", chg_flag, 8'h00);
    check("irq", irq_line, 8'h01);
    $display("test change flag done");
    tick(1);
    d = $urandom;
    {modem_pins_a, modem_pins_b} <= 2'h3;
    dtr_n_a <= d[0];
    dtr_n_b <= ~d[0];
    gpio_in <= d[15:8];
    tick(4);
    #1;
    check("gpio_oe", gpio_oe_n, 8'hdd);
    check("dtr", {gpio_out[5], gpio_out[1]}, {d[0], ~d[0]});
    check("state", gpio_state, d[15:8]);
    check("modem_b", min_b, {d[8], d[10], d[11]});
    check("modem_a", min_a, {d[12], d[14], d[15]});
    check("flag", chg_flag, 8'h00);
    $display("test modem done");
    report_and_stop();
  end
endmodule : test_host_pin_function_select
`default_nettype wire
